// File: hdl/rtcrb_defs.vh
/*
  Constants for the calendar register block: the register map, control bit
  positions, the control reset value, the BCD limits and the timing figures.
  Assumes the including file is plain Verilog-2005 and uses these only as
  constants.
*/
`ifndef RTCRB_DEFS_VH
`define RTCRB_DEFS_VH

// ****************************************************************
// register map
// ****************************************************************
`define RTCRB_SECONDS_COUNT   6'h00
`define RTCRB_MINUTES_COUNT   6'h01
`define RTCRB_HOURS_COUNT     6'h02
`define RTCRB_WEEKDAY_COUNT   6'h03
`define RTCRB_DATE_COUNT      6'h04
`define RTCRB_MONTH_COUNT     6'h05
`define RTCRB_YEAR_COUNT      6'h06
`define RTCRB_OUTPUT_CONTROL  6'h07
`define RTCRB_STORAGE_FIRST   6'h08
`define RTCRB_STORAGE_LAST    6'h3f
`define RTCRB_STORAGE_DEPTH   56

// ****************************************************************
// field positions and masks
// ****************************************************************
`define RTCRB_HALT_BIT        7
`define RTCRB_HOUR12_BIT      6
`define RTCRB_MERIDIEM_BIT    5
`define RTCRB_OUT_LEVEL_BIT   7
`define RTCRB_STOP_FLAG_BIT   5
`define RTCRB_WAVE_EN_BIT     4
`define RTCRB_RATE_HI_BIT     1
`define RTCRB_RATE_LO_BIT     0
`define RTCRB_MASK_SECONDS    8'hff
`define RTCRB_MASK_MINUTES    8'h7f
`define RTCRB_MASK_HOURS      8'h7f
`define RTCRB_MASK_WEEKDAY    8'h07
`define RTCRB_MASK_DATE       8'h3f
`define RTCRB_MASK_MONTH      8'h1f
`define RTCRB_MASK_YEAR       8'hff
`define RTCRB_MASK_CONTROL    8'hb3

// ****************************************************************
// reset values
// ****************************************************************
`define RTCRB_CONTROL_RESET   8'hb3
`define RTCRB_SECONDS_RESET   8'h80
`define RTCRB_DATE_RESET      8'h01

// ****************************************************************
// bcd limits
// ****************************************************************
`define RTCRB_BCD_59          8'h59
`define RTCRB_BCD_23          8'h23
`define RTCRB_BCD_12          8'h12
`define RTCRB_BCD_11          8'h11
`define RTCRB_BCD_99          8'h99
`define RTCRB_WEEKDAY_LAST    8'h07

// ****************************************************************
// timing
// ****************************************************************
`define RTCRB_CLK_MHZ         100
`define RTCRB_OSC_LOSS_US     200
`define RTCRB_DIV_WIDTH       15
`define RTCRB_DIV_TAP_1HZ     14
`define RTCRB_DIV_TAP_4K      2
`define RTCRB_DIV_TAP_8K      1

`endif

// File: hdl/rtcrb_block.v
/*
  Calendar register block: BCD time and date counters, control register for
  the wave output pin, oscillator stop flag and 56 bytes of storage, all in
  one 64-location space behind an auto-incrementing pointer.
  Assumes a two-wire slave engine on clk_i supplies one-cycle strobes for
  start, stop, pointer load, byte write (at the acknowledge) and byte read,
  at most one per cycle; the 32.768 kHz oscillator and the power-fail level
  arrive asynchronously and are sampled here.
*/
`timescale 1ns/1ns
`include "rtcrb_defs.vh"

module rtcrb_block #(
  parameter OSC_LOSS_CYC = `RTCRB_OSC_LOSS_US * `RTCRB_CLK_MHZ
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       reset_n_i,
  // asynchronous inputs
  input  wire       osc_clk_i,
  input  wire       power_fail_i,
  // byte strobes from the serial engine
  input  wire       bus_start_i,
  input  wire       bus_stop_i,
  input  wire       ptr_load_i,
  input  wire       wr_byte_i,
  input  wire       rd_byte_i,
  input  wire [7:0] wr_data_i,
  // read data toward the serial engine
  output reg  [7:0] rd_data_o,
  output reg  [5:0] reg_ptr_o,
  // wave output pin
  output reg        wave_output_pin_o
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // packed bcd increment, no range check
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last date of a month, bcd, with leap years for year 00-99
  function [7:0] month_last;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
      leap = (~yr[4] & (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) |
             (yr[4] & (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
      case (mon)
        8'h02:   month_last = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
        default: month_last = 8'h31;
      endcase
    end
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [2:0] osc_sync;
  reg [2:0] pf_sync;
  reg       osc_level;
  reg       power_fail;

  // three stages; a change counts when stages two and three agree
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      {osc_sync, pf_sync, osc_level, power_fail} <= 8'h00;
    end else begin
      osc_sync <= {osc_sync[1:0], osc_clk_i};
      pf_sync  <= {pf_sync[1:0], power_fail_i};
      if (osc_sync[2] == osc_sync[1]) begin
        osc_level <= osc_sync[2];
      end
      if (pf_sync[2] == pf_sync[1]) begin
        power_fail <= pf_sync[2];
      end
    end
  end

  wire osc_rise = (osc_sync[2] == osc_sync[1]) & osc_sync[2] & ~osc_level;

  // host strobes are ignored while main supply is low
  wire acc_ok   = ~power_fail;
  wire do_start = acc_ok & bus_start_i;
  wire do_stop  = acc_ok & bus_stop_i;
  wire do_load  = acc_ok & ptr_load_i;
  wire do_wr    = acc_ok & wr_byte_i;
  wire do_rd    = acc_ok & rd_byte_i;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] seconds_count;
  reg [7:0] minutes_count;
  reg [7:0] hours_count;
  reg [7:0] weekday_count;
  reg [7:0] date_count;
  reg [7:0] month_count;
  reg [7:0] year_count;
  reg [7:0] output_and_status_control;
  reg [7:0] general_storage [0:`RTCRB_STORAGE_DEPTH-1];
  reg [55:0] shadow;
  reg [`RTCRB_DIV_WIDTH-1:0] div_cnt;
  reg [15:0] loss_cnt;
  reg        osc_running;

  // oscillator halt bit and loss of oscillator edges both stop it
  wire halted    = seconds_count[`RTCRB_HALT_BIT];
  wire osc_lost  = (loss_cnt >= OSC_LOSS_CYC[15:0]);
  wire run_now   = ~halted & ~osc_lost;
  wire osc_tick  = osc_rise & ~halted;
  wire sec_tick  = osc_tick & (&div_cnt);

  // pointer increment after each stored or returned byte
  wire       step    = do_wr | do_rd;
  wire [5:0] ptr_inc = reg_ptr_o + 6'h01;
  wire       wrap0   = step & (ptr_inc == `RTCRB_SECONDS_COUNT);
  wire       in_ram  = (reg_ptr_o >= `RTCRB_STORAGE_FIRST);
  wire [5:0] ram_idx = reg_ptr_o - `RTCRB_STORAGE_FIRST;

  // ****************************************************************
  // oscillator watch and sub-second divider
  // ****************************************************************
  // count clk cycles since the last oscillator edge
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      {loss_cnt, osc_running} <= 17'h00000;
    end else begin
      osc_running <= run_now;
      if (osc_rise) begin
        loss_cnt <= 16'h0000;
      end else if (!osc_lost) begin
        loss_cnt <= loss_cnt + 16'h0001;
      end
    end
  end

  // divider restarts on any seconds write
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_cnt <= {`RTCRB_DIV_WIDTH{1'b0}};
    end else if (do_wr && reg_ptr_o == `RTCRB_SECONDS_COUNT) begin
      div_cnt <= {`RTCRB_DIV_WIDTH{1'b0}};
    end else if (osc_tick) begin
      div_cnt <= div_cnt + {{(`RTCRB_DIV_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************************************
  // calendar counters and host writes
  // ****************************************************************
  reg [7:0] next_sec;
  reg [7:0] next_min;
  reg [7:0] next_hour;
  reg [7:0] next_wday;
  reg [7:0] next_date;
  reg [7:0] next_mon;
  reg [7:0] next_year;
  reg       c_min;
  reg       c_hour;
  reg       c_day;
  reg       c_mon;
  reg       c_year;

  // carry chain from the one-second tick
  always @* begin
    next_sec  = seconds_count;
    next_min  = minutes_count;
    next_hour = hours_count;
    next_wday = weekday_count;
    next_date = date_count;
    next_mon  = month_count;
    next_year = year_count;
    c_min     = 1'b0;
    c_hour    = 1'b0;
    c_day     = 1'b0;
    c_mon     = 1'b0;
    c_year    = 1'b0;
    if (sec_tick) begin
      // seconds and minutes 00-59
      if (seconds_count[6:0] == `RTCRB_BCD_59) begin
        next_sec = {seconds_count[7], 7'h00};
        c_min    = 1'b1;
      end else begin
        next_sec = bcd_inc({1'b0, seconds_count[6:0]}) | {seconds_count[7], 7'h00};
      end
    end
    if (c_min) begin
      if (minutes_count == `RTCRB_BCD_59) begin
        next_min = 8'h00;
        c_hour   = 1'b1;
      end else begin
        next_min = bcd_inc(minutes_count);
      end
    end
    if (c_hour) begin
      if (hours_count[`RTCRB_HOUR12_BIT]) begin
        // twelve-hour: 12, 1 .. 11, meridiem toggles at 11 to 12
        if (hours_count[4:0] == `RTCRB_BCD_11) begin
          next_hour = {hours_count[7:6], ~hours_count[5], 5'h12};
          c_day     = hours_count[`RTCRB_MERIDIEM_BIT];
        end else if (hours_count[4:0] == `RTCRB_BCD_12) begin
          next_hour = {hours_count[7:5], 5'h01};
        end else begin
          next_hour = bcd_inc({3'h0, hours_count[4:0]}) | {hours_count[7:5], 5'h00};
        end
      end else if (hours_count[5:0] == `RTCRB_BCD_23) begin
        // twenty-four hour, bit 5 is the twenties digit
        next_hour = {hours_count[7:6], 6'h00};
        c_day     = 1'b1;
      end else begin
        next_hour = bcd_inc({2'h0, hours_count[5:0]}) | {hours_count[7:6], 6'h00};
      end
    end
    if (c_day) begin
      // weekday 1-7, advanced at midnight
      next_wday = (weekday_count == `RTCRB_WEEKDAY_LAST) ? 8'h01 :
                  bcd_inc(weekday_count);
      // month length and leap years
      if (date_count == month_last(month_count, year_count)) begin
        next_date = 8'h01;
        c_mon     = 1'b1;
      end else begin
        next_date = bcd_inc(date_count);
      end
    end
    if (c_mon) begin
      if (month_count == `RTCRB_BCD_12) begin
        next_mon = 8'h01;
        c_year   = 1'b1;
      end else begin
        next_mon = bcd_inc(month_count);
      end
    end
    if (c_year) begin
      next_year = (year_count == `RTCRB_BCD_99) ? 8'h00 : bcd_inc(year_count);
    end
  end

  // counters take the tick result, a host write to one register wins
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      {seconds_count, minutes_count, hours_count, weekday_count, date_count,
       month_count, year_count} <= {`RTCRB_SECONDS_RESET, 8'h00, 8'h00, 8'h01,
       `RTCRB_DATE_RESET, `RTCRB_DATE_RESET, 8'h00};
    end else begin
      {seconds_count, minutes_count, hours_count, weekday_count, date_count,
       month_count, year_count} <= {next_sec, next_min, next_hour, next_wday,
       next_date, next_mon, next_year};
      if (do_wr) begin
        // fixed zero bits are masked off on write
        case (reg_ptr_o)
          `RTCRB_SECONDS_COUNT: seconds_count <= wr_data_i & `RTCRB_MASK_SECONDS;
          `RTCRB_MINUTES_COUNT: minutes_count <= wr_data_i & `RTCRB_MASK_MINUTES;
          `RTCRB_HOURS_COUNT:   hours_count   <= wr_data_i & `RTCRB_MASK_HOURS;
          `RTCRB_WEEKDAY_COUNT: weekday_count <= wr_data_i & `RTCRB_MASK_WEEKDAY;
          `RTCRB_DATE_COUNT:    date_count    <= wr_data_i & `RTCRB_MASK_DATE;
          `RTCRB_MONTH_COUNT:   month_count   <= wr_data_i & `RTCRB_MASK_MONTH;
          `RTCRB_YEAR_COUNT:    year_count    <= wr_data_i & `RTCRB_MASK_YEAR;
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // stop flag set on run to stopped; set beats a clearing write
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      output_and_status_control <= `RTCRB_CONTROL_RESET;
    end else begin
      if (do_wr && reg_ptr_o == `RTCRB_OUTPUT_CONTROL) begin
        output_and_status_control <= (wr_data_i & `RTCRB_MASK_CONTROL &
                                      ~(8'h01 << `RTCRB_STOP_FLAG_BIT)) |
                                     ({7'h00, wr_data_i[`RTCRB_STOP_FLAG_BIT] &
                                       output_and_status_control[`RTCRB_STOP_FLAG_BIT]}
                                      << `RTCRB_STOP_FLAG_BIT);
      end
      if (osc_running && !run_now) begin
        output_and_status_control[`RTCRB_STOP_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  // plain storage, no reset, contents kept across supply loss
  always @(posedge clk_i) begin
    if (do_wr && in_ram) begin
      general_storage[ram_idx] <= wr_data_i;
    end
  end

  // ****************************************************************
  // pointer and read buffer
  // ****************************************************************
  // pointer loads from first write byte, steps after each byte
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_ptr_o <= 6'h00;
    end else if (do_load) begin
      reg_ptr_o <= wr_data_i[5:0];
    end else if (step) begin
      reg_ptr_o <= ptr_inc; // wraps 3f to 00
    end
  end

  // copy time into the read buffer on start, stop, rollover
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      shadow <= 56'h00000000000000;
    end else if (do_start || do_stop || wrap0) begin
      shadow <= {year_count, month_count, date_count, weekday_count,
                 hours_count, minutes_count, seconds_count};
    end
  end

  // read data follows the pointer one cycle later
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
    end else if (in_ram) begin
      rd_data_o <= general_storage[ram_idx];
    end else if (reg_ptr_o == `RTCRB_OUTPUT_CONTROL) begin
      rd_data_o <= output_and_status_control & `RTCRB_MASK_CONTROL;
    end else begin
      rd_data_o <= shadow[{reg_ptr_o[2:0], 3'h0} +: 8];
    end
  end

  // ****************************************************************
  // wave output pin
  // ****************************************************************
  reg wave_src;
  // rate select taps on the divider, or the oscillator level gated off by the halt bit at 11
  always @*
    case ({output_and_status_control[`RTCRB_RATE_HI_BIT],
           output_and_status_control[`RTCRB_RATE_LO_BIT]})
      2'b00:   wave_src = div_cnt[`RTCRB_DIV_TAP_1HZ];
      2'b01:   wave_src = div_cnt[`RTCRB_DIV_TAP_4K];
      2'b10:   wave_src = div_cnt[`RTCRB_DIV_TAP_8K];
      default: wave_src = osc_level & ~halted;
    endcase

  // enabled wave or static level bit
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      wave_output_pin_o <= 1'b1;
    end else if (output_and_status_control[`RTCRB_WAVE_EN_BIT]) begin
      wave_output_pin_o <= wave_src;
    end else begin
      wave_output_pin_o <= output_and_status_control[`RTCRB_OUT_LEVEL_BIT];
    end
  end

endmodule

// File: verif/rtcrb_block_sva.sv
/*
  Port checker for the calendar register block: pointer, power-fail and
  wave pin behaviour. Assumes the power-fail level reaches the block
  through a three-flop sampler and is bound onto every block instance.
*/
`timescale 1ns/1ns

module rtcrb_block_sva #(
  parameter OSC_LOSS_CYC = 20000
) (
  // clock and reset
  input wire       clk_i,
  input wire       reset_n_i,
  // block inputs
  input wire       osc_clk_i,
  input wire       power_fail_i,
  input wire       bus_start_i,
  input wire       bus_stop_i,
  input wire       ptr_load_i,
  input wire       wr_byte_i,
  input wire       rd_byte_i,
  input wire [7:0] wr_data_i,
  // block outputs
  input wire [7:0] rd_data_o,
  input wire [5:0] reg_ptr_o,
  input wire       wave_output_pin_o
);
  reg  [4:0] pf_hist;
  reg  [7:0] ctl_q;
  reg  [2:0] ctl_age;
  wire       pf_ok  = (pf_hist == 5'h00);
  wire       pf_hot = (pf_hist == 5'h1f);
  wire       quiet  = !ptr_load_i && !wr_byte_i && !rd_byte_i;
  wire       ctl_wr = wr_byte_i && pf_ok && (reg_ptr_o == 6'h07);
  wire [5:0] wr_ptr = wr_data_i[5:0];

  // power-fail history, copy of the wave control bits and their age
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pf_hist <= 5'h0a;
      ctl_q   <= 8'h93;
      ctl_age <= 3'h0;
    end else begin
      pf_hist <= {pf_hist[3:0], power_fail_i};
      ctl_q   <= ctl_wr ? (wr_data_i & 8'h93) : ctl_q;
      ctl_age <= ctl_wr ? 3'h0 : ((ctl_age == 3'h7) ? ctl_age : ctl_age + 3'h1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_reset_state: assert property (disable iff (1'b0)
    (!reset_n_i) [*2] |-> reg_ptr_o == 6'h00 && wave_output_pin_o)
    else $error("outputs not at reset state");
  a_ptr_load: assert property (
    ptr_load_i && pf_ok |=> reg_ptr_o == $past(wr_ptr))
    else $error("pointer not loaded from byte");
  a_ptr_step: assert property (
    (wr_byte_i || rd_byte_i) && pf_ok |=> reg_ptr_o == $past(reg_ptr_o) + 6'h01)
    else $error("pointer did not step by one");
  a_ptr_wrap: assert property (
    reg_ptr_o == 6'h3f && (wr_byte_i || rd_byte_i) && pf_ok |=> reg_ptr_o == 6'h00)
    else $error("pointer did not wrap to zero");
  a_ptr_quiet: assert property (
    quiet && pf_ok |=> $stable(reg_ptr_o))
    else $error("pointer moved without a strobe");
  a_ptr_frozen: assert property (
    pf_hot |=> $stable(reg_ptr_o))
    else $error("pointer moved during power fail");
  a_wave_level: assert property (
    ctl_age == 3'h7 && !ctl_q[4] |-> wave_output_pin_o == ctl_q[7])
    else $error("static pin level differs from level bit");
  a_wave_moves: assert property (
    ctl_age == 3'h7 && ctl_q[4] && (ctl_q[1] ^ ctl_q[0]) |-> ##[1:60]
    $changed(wave_output_pin_o))
    else $error("enabled wave output stuck");
endmodule

bind rtcrb_block rtcrb_block_sva #(.OSC_LOSS_CYC(OSC_LOSS_CYC)) i_sva (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .osc_clk_i(osc_clk_i),
  .power_fail_i(power_fail_i), .bus_start_i(bus_start_i), .bus_stop_i(bus_stop_i),
  .ptr_load_i(ptr_load_i), .wr_byte_i(wr_byte_i), .rd_byte_i(rd_byte_i),
  .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .reg_ptr_o(reg_ptr_o),
  .wave_output_pin_o(wave_output_pin_o));

// File: verif/rtcrb_host_model.sv
/*
  Strobe-level bus master for the calendar register block: start, pointer
  byte, data bytes, reads and stop. Assumes the serial engine reduces
  the wire protocol to one-cycle strobes sampled on the rising edge.
*/
`timescale 1ns/1ns

module rtcrb_host_model (
  // clock
  input  wire       clk_i,
  // strobes toward the block
  output reg        bus_start_o,
  output reg        bus_stop_o,
  output reg        ptr_load_o,
  output reg        wr_byte_o,
  output reg        rd_byte_o,
  output reg  [7:0] wr_data_o,
  // read data from the block
  input  wire [7:0] rd_data_i
);
  // idle bus at time zero
  initial begin
    {bus_start_o, bus_stop_o, ptr_load_o, wr_byte_o, rd_byte_o} = 5'h00;
    wr_data_o = 8'h00;
  end

  // one strobe cycle with its byte, released data line toggles, then quiet
  task automatic strobe(input [4:0] s, input [7:0] b);
    begin
      @(negedge clk_i);
      {bus_start_o, bus_stop_o, ptr_load_o, wr_byte_o, rd_byte_o} = s;
      wr_data_o = b;
      @(negedge clk_i);
      {bus_start_o, bus_stop_o, ptr_load_o, wr_byte_o, rd_byte_o} = 5'h00;
      wr_data_o = ~b;
      repeat (3) @(negedge clk_i);
    end
  endtask

  // pointer byte then n data bytes back to back, well inside one second
  // callers set hours after a mode change and clear halt early
  task automatic xfer_write(input [5:0] p, input integer n, input [63:0] v);
    integer i;
    begin
      strobe(5'h10, ~wr_data_o);
      strobe(5'h04, {2'b00, p});
      for (i = 0; i < n; i = i + 1)
        strobe(5'h02, v[8*i +: 8]);
      strobe(5'h08, ~wr_data_o);
    end
  endtask

  // read n bytes from the current pointer
  task automatic xfer_read(input integer n, output [63:0] v);
    integer i;
    begin
      v = 64'h0;
      strobe(5'h10, ~wr_data_o);
      for (i = 0; i < n; i = i + 1) begin
        v[8*i +: 8] = rd_data_i;
        strobe(5'h01, ~wr_data_o);
      end
      strobe(5'h08, ~wr_data_o);
    end
  endtask
endmodule

// File: verif/rtcrb_block_tb.sv
/*
  Self-checking bench for the calendar register block with a fast oscillator.
  Assumes the host model and the bound port checker beside the block.
*/
`timescale 1ns/1ns

module rtcrb_block_tb;
  reg         clk_i;
  reg         reset_n_i;
  reg         osc_clk_i;
  reg         power_fail_i;
  reg         osc_run = 1'b1;
  wire        bus_start;
  wire        bus_stop;
  wire        ptr_load;
  wire        wr_byte;
  wire        rd_byte;
  wire [7:0]  wr_data;
  wire [7:0]  rd_data;
  wire [5:0]  reg_ptr;
  wire        wave_pin;
  integer     mismatches;
  integer     checked;
  integer     cycles = 0;
  reg  [63:0] d;

  // system clock and oscillator that stands still while stopped
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    osc_clk_i = 1'b0;
    forever begin
      if (osc_run) begin
        #62 osc_clk_i = 1'b1;
        #63 osc_clk_i = 1'b0;
      end else
        #125 osc_clk_i = 1'b0;
    end
  end

  rtcrb_block #(.OSC_LOSS_CYC(200)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .osc_clk_i(osc_clk_i),
    .power_fail_i(power_fail_i), .bus_start_i(bus_start), .bus_stop_i(bus_stop),
    .ptr_load_i(ptr_load), .wr_byte_i(wr_byte), .rd_byte_i(rd_byte),
    .wr_data_i(wr_data), .rd_data_o(rd_data), .reg_ptr_o(reg_ptr),
    .wave_output_pin_o(wave_pin));
  rtcrb_host_model i_host (
    .clk_i(clk_i), .bus_start_o(bus_start), .bus_stop_o(bus_stop),
    .ptr_load_o(ptr_load), .wr_byte_o(wr_byte), .rd_byte_o(rd_byte),
    .wr_data_o(wr_data), .rd_data_i(rd_data));

  task automatic check(input [63:0] seen, input [63:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      if (mismatches == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // set the pointer with an empty write, then read n bytes
  task automatic rd(input [5:0] p, input integer n);
    begin
      i_host.xfer_write(p, 0, 64'h0);
      i_host.xfer_read(n, d);
    end
  endtask

  task automatic t_storage_wrap;
    begin
      i_host.xfer_write(6'h3e, 3, 64'h00_5a_a5);
      rd(6'h3e, 4);
      check(d[31:0], 32'h00_00_5a_a5);
      check(reg_ptr, 6'h02);
    end
  endtask

  task automatic t_fields;
    begin
      i_host.xfer_write(6'h01, 6, 64'h99_f2_f1_ff_72_d9);
      rd(6'h01, 6);
      check(d[47:0], 48'h99_12_31_07_72_59);
      i_host.xfer_write(6'h02, 1, 64'h23);
      rd(6'h02, 1);
      check(d[7:0], 8'h23);
    end
  endtask

  task automatic t_stop_flag;
    begin
      i_host.xfer_write(6'h07, 1, 64'h20);
      rd(6'h07, 1);
      check(d[7:0], 8'h20);
      i_host.xfer_write(6'h07, 1, 64'h00);
      i_host.xfer_write(6'h07, 1, 64'h20);
      rd(6'h07, 1);
      check(d[7:0], 8'h00);
      osc_run = 1'b0;
      repeat (400) @(negedge clk_i);
      osc_run = 1'b1;
      rd(6'h07, 1);
      check(d[7:0], 8'h20);
      i_host.xfer_write(6'h07, 1, 64'h00);
      i_host.xfer_write(6'h00, 1, 64'h80);
      repeat (400) @(negedge clk_i);
      rd(6'h07, 1);
      check(d[7:0], 8'h20);
      i_host.xfer_write(6'h00, 1, 64'h00);
    end
  endtask

  // static levels, then rising edges counted over 800 cycles per rate
  task automatic t_wave;
    integer rs;
    integer k;
    integer e;
    integer rises;
    reg     last;
    begin
      i_host.xfer_write(6'h07, 1, 64'h80);
      check(wave_pin, 1'b1);
      i_host.xfer_write(6'h07, 1, 64'h00);
      check(wave_pin, 1'b0);
      for (rs = 0; rs < 4; rs = rs + 1) begin
        i_host.xfer_write(6'h07, 1, 64'h10 | rs);
        e = (rs == 0) ? 0 : (rs == 1) ? 8 : (rs == 2) ? 16 : 64;
        rises = 0;
        last = wave_pin;
        for (k = 0; k < 800; k = k + 1) begin
          @(negedge clk_i);
          rises = rises + (wave_pin & ~last);
          last = wave_pin;
        end
        check(rises >= e - 1 && rises <= e + 1, 1'b1);
      end
    end
  endtask

  task automatic t_power_fail;
    begin
      i_host.xfer_write(6'h08, 1, 64'h3c);
      power_fail_i = 1'b1;
      repeat (6) @(negedge clk_i);
      i_host.xfer_write(6'h08, 1, 64'hc3);
      check(reg_ptr, 6'h09);
      power_fail_i = 1'b0;
      repeat (6) @(negedge clk_i);
      rd(6'h08, 1);
      check(d[7:0], 8'h3c);
    end
  endtask

  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  // reset, then the scenarios in order
  initial begin
    mismatches = 0;
    checked = 0;
    reset_n_i = 1'b0;
    power_fail_i = 1'b0;
    repeat (16) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(6'h07, 1);
    check(d[7:0], 8'hb3);
    t_storage_wrap;
    t_fields;
    t_stop_flag;
    t_wave;
    t_power_fail;
    give_verdict;
  end
endmodule
